//--- hcsu_map.vh
// Register map, field positions, reset values and counts of the channel status block
`ifndef HCSU_MAP_VH
`define HCSU_MAP_VH
`define HCSU_OFS_STATUS 8'h00
`define HCSU_OFS_CONTROL 8'h04
`define HCSU_OFS_IRQ_EN 8'h08
`define HCSU_B_FLAG 11
`define HCSU_B_CARRIER 12
`define HCSU_B_CAR_CHG 13
`define HCSU_B_FRAME_OK 14
`define HCSU_B_IDLE 15
`define HCSU_B_ABORT 16
`define HCSU_B_CHECK 17
`define HCSU_B_NON_OCT 18
`define HCSU_B_OVERRUN 19
`define HCSU_B_BUF_OVF 20
`define HCSU_B_TX_ABORT 22
`define HCSU_B_INT_ERR 23
`define HCSU_B_RX_DONE 24
`define HCSU_B_RX_NULL 25
`define HCSU_B_RX_NOWN 26
`define HCSU_B_TX_DONE 27
`define HCSU_B_TX_NULL 28
`define HCSU_B_TX_NOWN 29
`define HCSU_B_ONE_MISS 30
`define HCSU_B_TWO_MISS 31
`define HCSU_C_RX_DMA 0
`define HCSU_C_TX_DMA 1
`define HCSU_C_RX_SKIP 2
`define HCSU_C_TX_SKIP 3
`define HCSU_C_LOOP_EN 4
`define HCSU_C_CODE_HI 6
`define HCSU_CTRL_MASK 32'h0000007f
`define HCSU_STICKY_MASK 32'hffdfe800
`define HCSU_STATUS_RST 32'h00000000
`define HCSU_CONTROL_RST 32'h00000000
`define HCSU_IRQ_EN_RST 32'h00000000
`define HCSU_FLAG_PATTERN 8'h7e
`define HCSU_IDLE_ONES 4'hf
`define HCSU_ABORT_ONES 4'h7
`endif

//--- hcsu_status.v
// Upper status bits of one serial channel with their control and enable registers
`timescale 1ns/1ps
`include "hcsu_map.vh"

module hcsu_status (
   // Clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // Register port
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output wire [31:0] o_rdata,
   // Line pins
   input wire i_carrier_in_n,
   input wire i_rx_link_clk,
   input wire i_rx_data,
   // Receive path events
   input wire i_rx_frame_end,
   input wire i_rx_frame_err,
   input wire i_check_fail,
   input wire i_non_octet,
   input wire i_rx_fifo_push,
   input wire i_rx_fifo_full,
   input wire i_rx_clk_unstable,
   // DMA events
   input wire i_no_rx_buffer,
   input wire i_rx_dma_frame_done,
   input wire i_rx_null_ptr,
   input wire i_rx_not_owned,
   input wire i_tx_abort_sent,
   input wire i_tx_dma_frame_done,
   input wire i_tx_null_ptr,
   input wire i_tx_not_owned,
   // Control outputs
   output wire o_receive_dma_enable,
   output wire o_transmit_dma_enable,
   output wire o_receive_stop_skip,
   output wire o_transmit_stop_skip,
   output wire o_rx_fifo_clear,
   output wire o_rx_fifo_overwrite,
   output wire o_loop_search,
   output wire o_in_frame,
   output wire o_status_irq
);

   // One-hot register select, shared by reads and writes
   function [2:0] hcsu_sel;
      input [7:0] addr;
      begin
         if (addr == `HCSU_OFS_STATUS) begin
            hcsu_sel = 3'h1;
         end else if (addr == `HCSU_OFS_CONTROL) begin
            hcsu_sel = 3'h2;
         end else if (addr == `HCSU_OFS_IRQ_EN) begin
            hcsu_sel = 3'h4;
         end else begin
            hcsu_sel = 3'h0;
         end
      end
   endfunction

   reg [31:0] status_ff;
   reg [31:0] nxt_status;
   reg [31:0] ctrl_ff;
   reg [31:0] nxt_ctrl;
   reg [31:0] ien_ff;
   reg [31:0] rdata_ff;
   reg irq_ff;
   reg abort_frame_ff;
   reg fifo_clear_ff;
   reg overwrite_ff;

   // Pin synchronisers and previous-value stages
   reg dcd_m_ff;
   reg dcd_s_ff;
   reg dcd_p_ff;
   reg lclk_m_ff;
   reg lclk_s_ff;
   reg lclk_p_ff;
   reg rxd_m_ff;
   reg rxd_s_ff;
   reg rxd_p_ff;

   // Receive bit tracking
   reg [7:0] shift_ff;
   reg [3:0] ones_ff;
   reg [3:0] nxt_ones;
   reg in_frame_ff;
   reg edge_seen_ff;
   reg missed_once_ff;
   reg search_ff;

   wire [2:0] wsel = i_wr ? hcsu_sel(i_addr) : 3'h0;
   wire [2:0] rsel = i_rd ? hcsu_sel(i_addr) : 3'h0;

   wire lclk_rise = lclk_s_ff & ~lclk_p_ff;
   wire data_edge = rxd_s_ff ^ rxd_p_ff;
   wire bit_in = rxd_s_ff;
   wire [7:0] shift_nxt = {shift_ff[6:0], bit_in};

   wire rx_skip = ctrl_ff[`HCSU_C_RX_SKIP];
   wire tx_skip = ctrl_ff[`HCSU_C_TX_SKIP];
   wire fm_mode = ctrl_ff[`HCSU_C_LOOP_EN] & ctrl_ff[`HCSU_C_CODE_HI];

   // Line events on each sampled bit; carrier change on any clock
   wire flag_hit = lclk_rise & (shift_nxt == `HCSU_FLAG_PATTERN);
   wire idle_hit = lclk_rise & bit_in & (nxt_ones == `HCSU_IDLE_ONES);
   wire abort_hit = lclk_rise & bit_in & (ones_ff == (`HCSU_ABORT_ONES - 4'h1));
   wire carrier_chg = dcd_s_ff ^ dcd_p_ff;
   wire edge_now = edge_seen_ff | data_edge;
   wire miss_hit = lclk_rise & fm_mode & ~edge_now;
   wire one_miss = miss_hit & ~missed_once_ff;
   wire two_miss = miss_hit & missed_once_ff;

   // DMA stops
   wire rx_nown = i_rx_not_owned & rx_skip;
   wire tx_nown = i_tx_not_owned & tx_skip;
   wire rx_kill = i_no_rx_buffer | i_rx_null_ptr | rx_nown;
   wire tx_kill = i_tx_abort_sent | i_tx_null_ptr | tx_nown;

   wire [31:0] clr_v = wsel[0] ? (i_wdata & `HCSU_STICKY_MASK) : 32'h00000000;
   wire [31:0] set_v;
   wire [31:0] zero_v;
   wire [31:0] irq_src;

   assign set_v[10:0] = 11'h000;
   assign set_v[`HCSU_B_FLAG] = flag_hit;
   assign set_v[`HCSU_B_CARRIER] = 1'b0;
   assign set_v[`HCSU_B_CAR_CHG] = carrier_chg;
   assign set_v[`HCSU_B_FRAME_OK] = i_rx_frame_end & ~i_rx_frame_err;
   assign set_v[`HCSU_B_IDLE] = idle_hit;
   assign set_v[`HCSU_B_ABORT] = abort_hit;
   assign set_v[`HCSU_B_CHECK] = i_check_fail;
   assign set_v[`HCSU_B_NON_OCT] = i_non_octet;
   assign set_v[`HCSU_B_OVERRUN] = i_rx_fifo_push & i_rx_fifo_full;
   assign set_v[`HCSU_B_BUF_OVF] = i_no_rx_buffer;
   assign set_v[21] = 1'b0;
   assign set_v[`HCSU_B_TX_ABORT] = i_tx_abort_sent;
   assign set_v[`HCSU_B_INT_ERR] = i_rx_clk_unstable;
   assign set_v[`HCSU_B_RX_DONE] = i_rx_dma_frame_done;
   assign set_v[`HCSU_B_RX_NULL] = i_rx_null_ptr;
   assign set_v[`HCSU_B_RX_NOWN] = rx_nown;
   assign set_v[`HCSU_B_TX_DONE] = i_tx_dma_frame_done;
   assign set_v[`HCSU_B_TX_NULL] = i_tx_null_ptr;
   assign set_v[`HCSU_B_TX_NOWN] = tx_nown;
   assign set_v[`HCSU_B_ONE_MISS] = one_miss;
   assign set_v[`HCSU_B_TWO_MISS] = two_miss;

   // Bits that must read zero in the current configuration
   assign zero_v = {~fm_mode, 1'b0, ~tx_skip, 2'h0, ~rx_skip, 26'h0000000};

   // Abort interrupt only for aborts seen inside a frame
   assign irq_src = {status_ff[31:17], abort_frame_ff, status_ff[15:13], 1'b0,
                     status_ff[11:0]} & `HCSU_STICKY_MASK;

   always @* begin
      nxt_status = (((status_ff & ~clr_v) | set_v) & `HCSU_STICKY_MASK) & ~zero_v;
      nxt_status[`HCSU_B_CARRIER] = ~dcd_s_ff;
   end

   // Hardware stops win over a simultaneous software write
   always @* begin
      nxt_ctrl = wsel[1] ? (i_wdata & `HCSU_CTRL_MASK) : ctrl_ff;
      if (rx_kill) begin
         nxt_ctrl[`HCSU_C_RX_DMA] = 1'b0;
      end
      if (tx_kill) begin
         nxt_ctrl[`HCSU_C_TX_DMA] = 1'b0;
      end
   end

   // Saturating run of received ones; a zero ends it
   always @* begin
      if (!bit_in) begin
         nxt_ones = 4'h0;
      end else if (ones_ff == `HCSU_IDLE_ONES) begin
         nxt_ones = ones_ff;
      end else begin
         nxt_ones = ones_ff + 4'h1;
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         dcd_m_ff <= 1'b1;
         dcd_s_ff <= 1'b1;
         dcd_p_ff <= 1'b1;
         lclk_m_ff <= 1'b0;
         lclk_s_ff <= 1'b0;
         lclk_p_ff <= 1'b0;
         rxd_m_ff <= 1'b1;
         rxd_s_ff <= 1'b1;
         rxd_p_ff <= 1'b1;
      end else begin
         dcd_m_ff <= i_carrier_in_n;
         dcd_s_ff <= dcd_m_ff;
         dcd_p_ff <= dcd_s_ff;
         lclk_m_ff <= i_rx_link_clk;
         lclk_s_ff <= lclk_m_ff;
         lclk_p_ff <= lclk_s_ff;
         rxd_m_ff <= i_rx_data;
         rxd_s_ff <= rxd_m_ff;
         rxd_p_ff <= rxd_s_ff;
      end
   end

   // Bit sampling on the rising link clock edge
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         shift_ff <= 8'h00;
         ones_ff <= 4'h0;
         in_frame_ff <= 1'b0;
      end else if (lclk_rise) begin
         shift_ff <= shift_nxt;
         ones_ff <= nxt_ones;
         if (abort_hit | idle_hit) begin
            in_frame_ff <= 1'b0;
         end else if (flag_hit) begin
            in_frame_ff <= 1'b1;
         end
      end
   end

   // Clock recovery edge watch, one attempt per link clock edge
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         edge_seen_ff <= 1'b0;
         missed_once_ff <= 1'b0;
         search_ff <= 1'b0;
      end else if (!fm_mode) begin
         edge_seen_ff <= 1'b0;
         missed_once_ff <= 1'b0;
         search_ff <= 1'b0;
      end else if (lclk_rise) begin
         edge_seen_ff <= 1'b0;
         if (edge_now) begin
            missed_once_ff <= 1'b0;
            search_ff <= 1'b0;
         end else begin
            missed_once_ff <= 1'b1;
            if (missed_once_ff) begin
               search_ff <= 1'b1;
            end
         end
      end else if (data_edge) begin
         edge_seen_ff <= 1'b1;
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         status_ff <= `HCSU_STATUS_RST;
         ctrl_ff <= `HCSU_CONTROL_RST;
         ien_ff <= `HCSU_IRQ_EN_RST;
      end else begin
         status_ff <= nxt_status;
         ctrl_ff <= nxt_ctrl;
         if (wsel[2]) begin
            ien_ff <= i_wdata & `HCSU_STICKY_MASK;
         end
      end
   end

   // In-frame abort memory; a new abort wins over its clear
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         abort_frame_ff <= 1'b0;
      end else if (abort_hit & in_frame_ff) begin
         abort_frame_ff <= 1'b1;
      end else if (clr_v[`HCSU_B_ABORT]) begin
         abort_frame_ff <= 1'b0;
      end
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         fifo_clear_ff <= 1'b0;
         overwrite_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         fifo_clear_ff <= i_rx_null_ptr;
         overwrite_ff <= i_rx_fifo_push & i_rx_fifo_full;
         irq_ff <= |(irq_src & ien_ff);
      end
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         rdata_ff <= 32'h00000000;
      end else if (rsel[0]) begin
         rdata_ff <= status_ff;
      end else if (rsel[1]) begin
         rdata_ff <= ctrl_ff;
      end else if (rsel[2]) begin
         rdata_ff <= ien_ff;
      end else begin
         rdata_ff <= 32'h00000000;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_receive_dma_enable = ctrl_ff[`HCSU_C_RX_DMA];
   assign o_transmit_dma_enable = ctrl_ff[`HCSU_C_TX_DMA];
   assign o_receive_stop_skip = ctrl_ff[`HCSU_C_RX_SKIP];
   assign o_transmit_stop_skip = ctrl_ff[`HCSU_C_TX_SKIP];
   assign o_rx_fifo_clear = fifo_clear_ff;
   assign o_rx_fifo_overwrite = overwrite_ff;
   assign o_loop_search = search_ff;
   assign o_in_frame = in_frame_ff;
   assign o_status_irq = irq_ff;

endmodule // hcsu_status

//--- hcsu_status_sva.sv
// Port-level assertions of the channel status block
`timescale 1ns/1ps
module hcsu_status_sva (
   // Clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // Register port
   input wire [7:0] i_addr,
   input wire i_rd,
   input wire [31:0] o_rdata,
   // Pins and events
   input wire i_carrier_in_n,
   input wire i_rx_fifo_push,
   input wire i_rx_fifo_full,
   input wire i_no_rx_buffer,
   input wire i_rx_null_ptr,
   input wire i_rx_not_owned,
   input wire i_tx_abort_sent,
   input wire i_tx_null_ptr,
   input wire i_tx_not_owned,
   // Controls
   input wire o_receive_dma_enable,
   input wire o_transmit_dma_enable,
   input wire o_receive_stop_skip,
   input wire o_transmit_stop_skip,
   input wire o_rx_fifo_clear,
   input wire o_rx_fifo_overwrite
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   property p_reserved; i_rd && i_addr == 8'h00 |=> o_rdata[10:0] == 11'h0 && !o_rdata[21]; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status bits set");
   property p_carrier; $stable(i_carrier_in_n)[*6] ##0 (i_rd && i_addr == 8'h00) |=>
      o_rdata[12] == !$past(i_carrier_in_n); endproperty
   a_carrier: assert property (p_carrier) else $error("carrier level wrong");
   property p_buf_ovf; i_no_rx_buffer |=> !o_receive_dma_enable; endproperty
   a_buf_ovf: assert property (p_buf_ovf) else $error("rx dma kept on");
   property p_tx_abort; i_tx_abort_sent |=> !o_transmit_dma_enable; endproperty
   a_tx_abort: assert property (p_tx_abort) else $error("tx dma kept on");
   property p_rx_null; i_rx_null_ptr |=> o_rx_fifo_clear && !o_receive_dma_enable; endproperty
   a_rx_null: assert property (p_rx_null) else $error("rx null not handled");
   property p_rx_nown; i_rx_not_owned && o_receive_stop_skip |=> !o_receive_dma_enable; endproperty
   a_rx_nown: assert property (p_rx_nown) else $error("rx owner stop missed");
   property p_tx_null; i_tx_null_ptr |=> !o_transmit_dma_enable; endproperty
   a_tx_null: assert property (p_tx_null) else $error("tx null not handled");
   property p_tx_nown; i_tx_not_owned && o_transmit_stop_skip |=> !o_transmit_dma_enable; endproperty
   a_tx_nown: assert property (p_tx_nown) else $error("tx owner stop missed");
   property p_overrun; i_rx_fifo_push && i_rx_fifo_full |=> o_rx_fifo_overwrite; endproperty
   a_overrun: assert property (p_overrun) else $error("overwrite missing");
endmodule // hcsu_status_sva
bind hcsu_status hcsu_status_sva u_sva (.*);

//--- hcsu_station.sv
// Remote station model: serial bits, link clock and carrier pin
`timescale 1ns/1ps
module hcsu_station (
   // Line pins
   output logic o_link_clk,
   output logic o_data,
   output logic o_carrier_n
);
   initial begin
      o_link_clk = 1'b0;
      o_data = 1'b1;
      o_carrier_n = 1'b1;
   end
   // Bits go out LSB first; the clock stands still between bursts
   task automatic send(input logic [31:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         o_data = b[i];
         #100 o_link_clk = 1'b1;
         #100 o_link_clk = 1'b0;
      end
      o_data = ~o_data;
   endtask
endmodule // hcsu_station

//--- hcsu_status_tb.sv
// Self-checking bench of the channel status block
`timescale 1ns/1ps
module hcsu_status_tb;
   typedef struct packed {logic [31:0] e; logic [31:0] m;} hcsu_note_t;
   logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, rd_d = 0;
   logic [7:0] i_addr = 0;
   logic [31:0] i_wdata = 0, ev = 0, cexp;
   wire [31:0] o_rdata;
   wire lclk, ldat, car_n, search, in_frame, irq;
   hcsu_note_t q[$];
   hcsu_note_t t;
   integer fails = 0, num_checks = 0, seed = 23124, k, b;
   int bits[13] = '{14, 17, 18, 19, 20, 22, 23, 24, 25, 26, 27, 28, 29};
   hcsu_station u_st (.o_link_clk(lclk), .o_data(ldat), .o_carrier_n(car_n));
   hcsu_status u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_carrier_in_n(car_n), .i_rx_link_clk(lclk), .i_rx_data(ldat),
      .i_rx_frame_end(ev[14]), .i_rx_frame_err(ev[21]), .i_check_fail(ev[17]),
      .i_non_octet(ev[18]), .i_rx_fifo_push(ev[19]), .i_rx_fifo_full(ev[19]),
      .i_rx_clk_unstable(ev[23]), .i_no_rx_buffer(ev[20]), .i_rx_dma_frame_done(ev[24]),
      .i_rx_null_ptr(ev[25]), .i_rx_not_owned(ev[26]), .i_tx_abort_sent(ev[22]),
      .i_tx_dma_frame_done(ev[27]), .i_tx_null_ptr(ev[28]), .i_tx_not_owned(ev[29]),
      .o_receive_dma_enable(), .o_transmit_dma_enable(), .o_receive_stop_skip(),
      .o_transmit_stop_skip(), .o_rx_fifo_clear(), .o_rx_fifo_overwrite(),
      .o_loop_search(search), .o_in_frame(in_frame), .o_status_irq(irq));
   initial forever #12.5 i_clk = ~i_clk;
   task automatic cmp(string s, logic [31:0] e, logic [31:0] v);
      num_checks++;
      if (v !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", s, e, v);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
      q.push_back({e & m, m});
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic pulse(logic [31:0] v);
      ev <= v;
      @(posedge i_clk);
      ev <= 32'h0;
      @(posedge i_clk);
   endtask
   task automatic outs(logic [2:0] e, logic [2:0] m);
      @(negedge i_clk);
      cmp("irq_frame_search", {29'h0, e & m}, {29'h0, {irq, in_frame, search} & m});
      @(posedge i_clk);
   endtask
   task automatic burst(logic [31:0] v, int n);
      u_st.send(v, n);
      repeat (6) @(posedge i_clk);
   endtask
   task automatic give_verdict;
      if (fails == 0 && num_checks > 0 && q.size() == 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge i_clk) rd_d <= i_rd;
   // Read data stand only in the cycle after the strobe
   always @(negedge i_clk) begin
      if (rd_d) begin
         t = q.pop_front();
         cmp("rdata", t.e, o_rdata & t.m);
      end
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      rd(8'h00, 32'h0, 32'hffffffff);
      rd(8'h04, 32'h0, 32'hffffffff);
      wr(8'h0c, 32'hffffffff);
      rd(8'h0c, 32'h0, 32'hffffffff);
      wr(8'h00, 32'hffffffff);
      rd(8'h00, 32'h0, 32'h002007ff);
      for (k = 0; k < 13; k++) begin
         b = bits[k];
         wr(8'h04, 32'hf);
         pulse(32'h1 << b);
         cexp = 32'hf;
         if (b == 20 || b == 25 || b == 26) cexp[0] = 1'b0;
         if (b == 22 || b == 28 || b == 29) cexp[1] = 1'b0;
         rd(8'h04, cexp, 32'hffffffff);
         rd(8'h00, 32'hffffffff, 32'h1 << b);
         wr(8'h00, $random(seed) & ~(32'h1 << b));
         rd(8'h00, 32'hffffffff, 32'h1 << b);
         wr(8'h00, 32'h1 << b);
         rd(8'h00, 32'h0, 32'h1 << b);
      end
      wr(8'h04, 32'h3);
      pulse(32'h24000000);
      rd(8'h04, 32'h3, 32'hffffffff);
      rd(8'h00, 32'h0, 32'h24000000);
      // Frame end flagged with an error must not mark the frame valid
      pulse(32'h00204000);
      rd(8'h00, 32'h0, 32'h00204000);
      wr(8'h08, 32'h01000000);
      pulse(32'h01000000);
      outs(3'b100, 3'b100);
      wr(8'h00, 32'h01000000);
      outs(3'b000, 3'b100);
      wr(8'h08, 32'h00002000);
      u_st.o_carrier_n = 1'b0;
      repeat (8) @(posedge i_clk);
      rd(8'h00, 32'h3000, 32'h3000);
      outs(3'b100, 3'b100);
      wr(8'h00, 32'h2000);
      rd(8'h00, 32'h1000, 32'h3000);
      wr(8'h08, 32'h00011000);
      outs(3'b000, 3'b100);
      burst(32'h7e, 8);
      rd(8'h00, 32'h0800, 32'h0800);
      outs(3'b010, 3'b010);
      burst(32'h7fff, 15);
      rd(8'h00, 32'h18000, 32'h18000);
      outs(3'b100, 3'b110);
      wr(8'h00, 32'h18000);
      burst(32'h1, 1);
      rd(8'h00, 32'h8000, 32'h18000);
      wr(8'h00, 32'h8000);
      burst(32'h2, 2);
      rd(8'h00, 32'h0, 32'h8000);
      wr(8'h04, 32'h50);
      wr(8'h00, 32'hffffffff);
      burst(32'hf, 4);
      rd(8'h00, 32'hc0000000, 32'hc0000000);
      outs(3'b001, 3'b001);
      burst(32'h5, 4);
      outs(3'b000, 3'b001);
      wr(8'h04, 32'h10);
      rd(8'h00, 32'h0, 32'h80000000);
      wr(8'h00, 32'hffffffff);
      burst(32'hf, 4);
      rd(8'h00, 32'h0, 32'h80000000);
      outs(3'b000, 3'b001);
      repeat (4) @(posedge i_clk);
      give_verdict();
   end
endmodule // hcsu_status_tb
